// file: bsr_defs.vh
// constants for the backup sram control register block
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH

// ========================================
// control byte and register addresses
`define BSR_CTRL_OPCODE     4'h3
`define BSR_ARRAY_OPCODE    4'hA
`define BSR_ADDR_STATUS     8'h00
`define BSR_ADDR_COMMAND    8'h55

// ========================================
// status register fields
`define BSR_BIT_MODIFIED    7
`define BSR_BIT_PROT_HI     4
`define BSR_BIT_PROT_LO     2
`define BSR_BIT_AUTO_EN     1
`define BSR_BIT_EVENT       0
`define BSR_STATUS_RESET    8'h00

// ========================================
// command codes
`define BSR_CMD_STORE       8'h33
`define BSR_CMD_RECALL      8'hDD

// ========================================
// timing in microseconds at 250 MHz (4 ns)
`define BSR_CLK_MHZ         250
`define BSR_STORE_US        8000
`define BSR_RECALL_US       100
`define BSR_WCYCLE_US       5000

`endif

// file: bsr_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module bsr_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_clk_sys,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // bsr_sync

// file: bsr_busy_timer.v
// down counter that holds the device busy for a chosen interval
`timescale 1ns/1ps
module bsr_busy_timer #(
    parameter WIDTH = 24
) (
    input  wire             i_clk_sys,
    input  wire             i_rst,
    input  wire             i_load,
    input  wire [WIDTH-1:0] i_count,
    output wire             o_busy,
    output wire             o_done
);
    reg [WIDTH-1:0] cnt_reg;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= {WIDTH{1'b0}};
        end else if (i_load) begin
            cnt_reg <= i_count;
        end else if (cnt_reg != {WIDTH{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign o_busy = (cnt_reg != {WIDTH{1'b0}});
    assign o_done = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // bsr_busy_timer

// file: bsr_ctrl_regs.v
// i2c control register slave: status, command, store/recall sequencing
//
// Overview of operation
// R1: any sram byte write sets modified flag
// R2: finished store or recall clears modified flag
// R3: auto/pin store needs flag; software always
// R4: modified flag bit 7, read-only, resets 0
// R5: protect field bits 4-2 selects region
// R6: protected ranges always end at top
// R7: auto-enable bit gates power-down store
// R8: without capacitor, system clears auto-enable
// R9: pin high sets event flag after store
// R10: bus write may set/clear event flag
// R11: pin ignored when low voltage or during store/recall
// R12: status write runs busy write cycle
// R13: store during write cycle is deferred
// R14: deferred auto store uses new enable
// R15: status bits 6 and 5 read zero
// R16: decode 33h store, DDh recall
// R17: software store ignores flags, naks meanwhile
// R18: software recall naks meanwhile, clears flag
// R19: command register is write-only
// R20: first byte after control is address
// R21: unknown address gets nak, wait start
// R22: master sends data after address ack
// R23: opcode 0011 selects control registers
// R24: status at 00h, command at 55h
// R25: bad command code gets nak
// R26: every register read returns status
// R27: busy intervals are parameters, nak throughout
`timescale 1ns/1ps
`include "bsr_defs.vh"
module bsr_ctrl_regs #(
    parameter        ARRAY_AW     = 9,
    parameter [23:0] STORE_CYC    = `BSR_STORE_US  * `BSR_CLK_MHZ,
    parameter [23:0] RECALL_CYC   = `BSR_RECALL_US * `BSR_CLK_MHZ,
    parameter [23:0] WCYCLE_CYC   = `BSR_WCYCLE_US * `BSR_CLK_MHZ,
    parameter [1:0]  CHIP_ADDR    = 2'b00
) (
    input  wire                i_clk_sys,
    input  wire                i_rst,
    input  wire                i_scl,
    input  wire                i_sda,
    output wire                o_sda,
    output wire                o_sda_oe,
    input  wire                i_manual_backup_pin,
    input  wire                i_cap_above_threshold,
    input  wire                i_array_byte_written,
    input  wire [ARRAY_AW-1:0] i_array_addr,
    output wire                o_array_addr_protected,
    output wire [7:0]          o_status,
    output wire                o_busy,
    output wire                o_store_start,
    output wire                o_recall_start
);
    // ========================================
    // pin sampling
    wire [3:0] pins_s;
    bsr_sync #(.WIDTH(4)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_scl, i_sda, i_manual_backup_pin, i_cap_above_threshold}),
        .o_sync    (pins_s)
    );
    wire scl_s = pins_s[3];
    wire sda_s = pins_s[2];
    wire hs_s  = pins_s[1];
    wire cap_s = pins_s[0];

    reg scl_d_reg;
    reg sda_d_reg;
    reg hs_d_reg;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b1;
            hs_d_reg  <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            hs_d_reg  <= hs_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire hs_rise  = hs_s & ~hs_d_reg;

    // ========================================
    // registers
    reg       modified_reg;
    reg [2:0] block_protect_field_reg;
    reg       auto_backup_enable_reg;
    reg       event_reg;
    assign o_status = {modified_reg, 2'b00, block_protect_field_reg, // R15
                       auto_backup_enable_reg, event_reg};           // R4

    // ========================================
    // protection: region always ends at top address
    reg [ARRAY_AW:0] prot_base;
    always @* begin
        case (block_protect_field_reg) // R5
            3'd0:    prot_base = {1'b1, {ARRAY_AW{1'b0}}};
            3'd7:    prot_base = {(ARRAY_AW+1){1'b0}};
            default: prot_base = {1'b0, {ARRAY_AW{1'b1}}} -
                     ({1'b0, {ARRAY_AW{1'b1}}} >> (3'd7 - block_protect_field_reg));
        endcase
    end
    assign o_array_addr_protected = ({1'b0, i_array_addr} >= prot_base); // R6

    // ========================================
    // i2c byte engine
    localparam ST_IDLE = 3'd0;
    localparam ST_CTRL = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_READ = 3'd4;
    localparam ST_IGN  = 3'd5;

    reg [2:0] state_reg;
    reg [3:0] bit_reg;
    reg [7:0] shift_reg;
    reg       ack_phase_reg;
    reg       ack_drive_reg;
    reg       tx_bit_reg;
    reg       tx_en_reg;
    reg       is_cmd_reg;
    reg       cmd_done_reg;
    reg       stat_pend_reg;
    reg [7:0] stat_data_reg;
    reg [7:0] rd_shift_reg;
    reg       sw_store_reg;
    reg       sw_recall_reg;
    reg       wr_commit_reg;

    wire busy;
    assign o_busy = busy;
    assign o_sda    = 1'b0;
    assign o_sda_oe = ack_drive_reg | (tx_en_reg & ~tx_bit_reg);

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_reg     <= ST_IDLE;
            bit_reg       <= 4'd0;
            shift_reg     <= 8'h00;
            ack_phase_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            tx_bit_reg    <= 1'b1;
            tx_en_reg     <= 1'b0;
            is_cmd_reg    <= 1'b0;
            cmd_done_reg  <= 1'b0;
            stat_pend_reg <= 1'b0;
            stat_data_reg <= 8'h00;
            rd_shift_reg  <= 8'h00;
            sw_store_reg  <= 1'b0;
            sw_recall_reg <= 1'b0;
            wr_commit_reg <= 1'b0;
        end else begin
            sw_store_reg  <= 1'b0;
            sw_recall_reg <= 1'b0;
            wr_commit_reg <= 1'b0;
            if (start_c) begin
                state_reg     <= busy ? ST_IGN : ST_CTRL; // R27
                bit_reg       <= 4'd0;
                ack_phase_reg <= 1'b0;
                ack_drive_reg <= 1'b0;
                tx_en_reg     <= 1'b0;
                stat_pend_reg <= 1'b0;
                cmd_done_reg  <= 1'b0;
            end else if (stop_c) begin
                if (stat_pend_reg && state_reg == ST_DATA)
                    wr_commit_reg <= 1'b1; // R12
                state_reg     <= ST_IDLE;
                stat_pend_reg <= 1'b0;
                ack_drive_reg <= 1'b0;
                tx_en_reg     <= 1'b0;
            end else if (busy && !cmd_done_reg && state_reg != ST_IDLE) begin
                // a store started mid transfer aborts the transfer
                state_reg     <= ST_IGN;
                ack_drive_reg <= 1'b0;
                tx_en_reg     <= 1'b0;
            end else if (scl_rise && !ack_phase_reg && state_reg != ST_IDLE
                         && state_reg != ST_IGN && state_reg != ST_READ) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_reg   <= bit_reg + 4'd1;
            end else if (scl_rise && ack_phase_reg && state_reg == ST_READ) begin
                if (sda_s)
                    state_reg <= ST_IGN; // master nak ends the read
            end else if (scl_fall) begin
                ack_drive_reg <= 1'b0;
                if (ack_phase_reg) begin
                    ack_phase_reg <= 1'b0;
                    bit_reg       <= 4'd0;
                    if (state_reg == ST_READ) begin
                        rd_shift_reg <= {o_status[6:0], 1'b0}; // R26
                        tx_bit_reg   <= o_status[7];
                        tx_en_reg    <= 1'b1;
                    end
                end else if (state_reg == ST_READ) begin
                    if (bit_reg == 4'd7) begin
                        tx_en_reg     <= 1'b0;
                        ack_phase_reg <= 1'b1;
                        bit_reg       <= 4'd0;
                    end else begin
                        tx_bit_reg   <= rd_shift_reg[7];
                        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                        bit_reg      <= bit_reg + 4'd1;
                    end
                end else if (bit_reg == 4'd8) begin
                    ack_phase_reg <= 1'b1;
                    case (state_reg)
                        ST_CTRL: begin
                            if (shift_reg[7:4] == `BSR_CTRL_OPCODE // R23
                                && shift_reg[3:2] == CHIP_ADDR) begin
                                ack_drive_reg <= 1'b1;
                                state_reg     <= shift_reg[0] ? ST_READ : ST_ADDR;
                            end else begin
                                state_reg <= ST_IGN;
                            end
                        end
                        ST_ADDR: begin
                            // address lives only for this transfer
                            if (shift_reg == `BSR_ADDR_STATUS) begin // R20 R24
                                ack_drive_reg <= 1'b1;
                                is_cmd_reg    <= 1'b0;
                                state_reg     <= ST_DATA;
                            end else if (shift_reg == `BSR_ADDR_COMMAND) begin // R24
                                ack_drive_reg <= 1'b1;
                                is_cmd_reg    <= 1'b1;
                                state_reg     <= ST_DATA;
                            end else begin
                                state_reg <= ST_IGN; // R21
                            end
                        end
                        ST_DATA: begin // R22
                            if (!is_cmd_reg) begin
                                // last status byte of a burst wins
                                ack_drive_reg <= 1'b1;
                                stat_data_reg <= shift_reg;
                                stat_pend_reg <= 1'b1;
                            end else if (!cmd_done_reg
                                         && shift_reg == `BSR_CMD_STORE) begin // R16
                                ack_drive_reg <= 1'b1;
                                cmd_done_reg  <= 1'b1;
                                sw_store_reg  <= 1'b1; // R17 R19
                            end else if (!cmd_done_reg
                                         && shift_reg == `BSR_CMD_RECALL) begin // R16
                                ack_drive_reg <= 1'b1;
                                cmd_done_reg  <= 1'b1;
                                sw_recall_reg <= 1'b1; // R18
                            end else begin
                                state_reg <= ST_IGN; // R25
                            end
                        end
                        default: state_reg <= ST_IGN;
                    endcase
                end
            end
        end
    end

    // ========================================
    // store / recall / write-cycle sequencer
    localparam SQ_IDLE   = 3'd0;
    localparam SQ_WCYC   = 3'd1;
    localparam SQ_STORE  = 3'd2;
    localparam SQ_RECALL = 3'd3;
    localparam SQ_EVWR   = 3'd4;

    reg [2:0] seq_reg;
    reg       hw_pend_reg;
    reg       auto_pend_reg;
    reg       ev_after_reg;
    reg       cap_d_reg;
    reg       load_reg;
    reg [23:0] load_val_reg;
    wire      t_busy;
    wire      t_done;

    bsr_busy_timer #(.WIDTH(24)) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_load    (load_reg),
        .i_count   (load_val_reg),
        .o_busy    (t_busy),
        .o_done    (t_done)
    );
    assign busy           = (seq_reg != SQ_IDLE) | sw_store_reg | sw_recall_reg; // R27
    assign o_store_start  = load_reg && (seq_reg == SQ_STORE);
    assign o_recall_start = load_reg && (seq_reg == SQ_RECALL);

    wire in_nv_op   = (seq_reg == SQ_STORE) | (seq_reg == SQ_RECALL);
    wire hs_trig    = hs_rise & cap_s & ~in_nv_op; // R11
    wire power_down = cap_d_reg & ~cap_s;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            seq_reg                 <= SQ_IDLE;
            hw_pend_reg             <= 1'b0;
            auto_pend_reg           <= 1'b0;
            ev_after_reg            <= 1'b0;
            cap_d_reg               <= 1'b0;
            load_reg                <= 1'b0;
            load_val_reg            <= 24'h00_0000;
            modified_reg            <= 1'b0;
            block_protect_field_reg <= 3'b000;
            auto_backup_enable_reg  <= 1'b0;
            event_reg               <= 1'b0;
        end else begin
            cap_d_reg <= cap_s;
            load_reg  <= 1'b0;
            // set beats the clear at the end of a store
            if (i_array_byte_written)
                modified_reg <= 1'b1; // R1
            else if (t_done && in_nv_op)
                modified_reg <= 1'b0; // R2
            case (seq_reg)
                SQ_IDLE: begin
                    if (wr_commit_reg) begin
                        {block_protect_field_reg, auto_backup_enable_reg, event_reg}
                            <= stat_data_reg[4:0]; // R10
                        seq_reg      <= SQ_WCYC; // R12
                        load_reg     <= 1'b1;
                        load_val_reg <= WCYCLE_CYC;
                    end else if (sw_store_reg) begin
                        seq_reg      <= SQ_STORE; // R17
                        load_reg     <= 1'b1;
                        load_val_reg <= STORE_CYC;
                    end else if (sw_recall_reg) begin
                        seq_reg      <= SQ_RECALL; // R18
                        load_reg     <= 1'b1;
                        load_val_reg <= RECALL_CYC;
                    end else if ((auto_pend_reg && auto_backup_enable_reg && modified_reg)
                                 || (hw_pend_reg && modified_reg)) begin // R3 R7 R13 R14
                        ev_after_reg  <= hw_pend_reg; // R9
                        hw_pend_reg   <= 1'b0;
                        auto_pend_reg <= 1'b0;
                        seq_reg       <= SQ_STORE;
                        load_reg      <= 1'b1;
                        load_val_reg  <= STORE_CYC;
                    end else if (hw_pend_reg) begin
                        hw_pend_reg   <= 1'b0;
                        auto_pend_reg <= 1'b0;
                        event_reg     <= 1'b1; // R9
                        seq_reg       <= SQ_EVWR;
                        load_reg      <= 1'b1;
                        load_val_reg  <= WCYCLE_CYC;
                    end else begin
                        auto_pend_reg <= 1'b0; // unmodified or disabled: no store
                    end
                end
                SQ_STORE: begin
                    if (t_done) begin
                        if (ev_after_reg) begin
                            ev_after_reg <= 1'b0;
                            event_reg    <= 1'b1; // R9
                            seq_reg      <= SQ_EVWR;
                            load_reg     <= 1'b1;
                            load_val_reg <= WCYCLE_CYC;
                        end else begin
                            seq_reg <= SQ_IDLE;
                        end
                    end
                end
                SQ_WCYC, SQ_RECALL, SQ_EVWR: begin
                    if (t_done)
                        seq_reg <= SQ_IDLE; // R13
                end
                default: seq_reg <= SQ_IDLE;
            endcase
            if (hs_trig) // after the case: a new request beats a clear
                hw_pend_reg <= 1'b1;
            if (power_down)
                auto_pend_reg <= 1'b1;
        end
    end
endmodule // bsr_ctrl_regs

// file: bsr_ctrl_regs_sva.sv
// port-level assertions for the control register block
`timescale 1ns/1ps
module bsr_ctrl_regs_sva #(
    parameter ARRAY_AW = 9
) (
    input wire                i_clk_sys,
    input wire                i_rst,
    input wire                i_scl,
    input wire                i_sda,
    input wire                o_sda,
    input wire                o_sda_oe,
    input wire                i_manual_backup_pin,
    input wire                i_cap_above_threshold,
    input wire                i_array_byte_written,
    input wire [ARRAY_AW-1:0] i_array_addr,
    input wire                o_array_addr_protected,
    input wire [7:0]          o_status,
    input wire                o_busy,
    input wire                o_store_start,
    input wire                o_recall_start
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ========================================
    // status contents and sda output level
    unused_bits_zero_a: assert property (o_status[6:5] == 2'h0)
        else $error("unimplemented status bits set");
    sda_low_a: assert property (!o_sda)
        else $error("sda driven high");
    modified_set_a: assert property (i_array_byte_written |=> o_status[7])
        else $error("array write did not set modified flag");
    modified_cause_a: assert property ($rose(o_status[7]) |-> $past(i_array_byte_written))
        else $error("modified flag rose without array write");
    // ========================================
    // store and recall
    store_busy_a: assert property (o_store_start |=> o_busy [*8])
        else $error("store without busy");
    recall_busy_a: assert property (o_recall_start |=> o_busy [*8])
        else $error("recall without busy");
    store_clear_a: assert property (o_store_start |-> ##[1:1000] !o_status[7])
        else $error("store did not clear modified flag");
    // 48 cycles leaves room for the ack bit that launched a command
    busy_nak_a: assert property (o_busy && $past(o_busy, 48) |-> !o_sda_oe)
        else $error("bus answered while busy");
    // ========================================
    // protection decode
    prot_none_a: assert property (o_status[4:2] == 3'h0 |-> !o_array_addr_protected)
        else $error("code 000 protects an address");
    prot_all_a: assert property (o_status[4:2] == 3'h7 |-> o_array_addr_protected)
        else $error("code 111 leaves an address open");
    prot_top_a: assert property ((o_status[4:2] != 3'h0) && (&i_array_addr) |->
        o_array_addr_protected) else $error("top address not protected");
endmodule // bsr_ctrl_regs_sva

bind bsr_ctrl_regs bsr_ctrl_regs_sva #(.ARRAY_AW(ARRAY_AW)) bsr_ctrl_regs_sva_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_manual_backup_pin(i_manual_backup_pin),
    .i_cap_above_threshold(i_cap_above_threshold), .i_array_byte_written(i_array_byte_written),
    .i_array_addr(i_array_addr), .o_array_addr_protected(o_array_addr_protected),
    .o_status(o_status), .o_busy(o_busy), .o_store_start(o_store_start),
    .o_recall_start(o_recall_start));

// file: bsr_i2c_master.sv
// behavioural i2c bus master that drives the control register block
`timescale 1ns/1ps
module bsr_i2c_master (
    input  wire  i_clk_sys,
    input  wire  i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    logic smp;
    // scl idles high between frames; sda is released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // a quarter of the 160 ns scl period
    task q;
        repeat (10) @(posedge i_clk_sys);
    endtask
    task start;
        q;
        o_sda_oe <= 1'b1;
        q;
        o_scl <= 1'b0;
        q;
    endtask
    task bit_out(input logic b);
        o_sda_oe <= ~b;
        q;
        o_scl <= 1'b1;
        q;
        smp = i_sda;
        q;
        o_scl <= 1'b0;
        q;
    endtask
    // ack is returned high when the device pulled sda low
    task send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_out(1'b1);
        ack = ~smp;
    endtask
    task recv(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b1);
            b[i] = smp;
        end
        bit_out(1'b1);
    endtask
    task stop;
        o_sda_oe <= 1'b1;
        q;
        o_scl <= 1'b1;
        q;
        o_sda_oe <= 1'b0;
        q;
    endtask
endmodule // bsr_i2c_master

// file: test_bsr_ctrl_regs.sv
// self-checking bench for the control register block
`timescale 1ns/1ps
module test_bsr_ctrl_regs;
    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic        hs        = 1'b0;
    logic        cap       = 1'b1;
    logic        awr       = 1'b0;
    logic        mod       = 1'b0;
    logic [8:0]  addr      = 9'h000;
    logic [31:0] rng       = 32'h859e_bb2d;
    logic [2:0]  ak;
    logic [7:0]  v, d;
    logic [8:0]  pa [5];
    wire         scl, m_oe, d_oe, busy, ss, rs, prot;
    wire [7:0]   st;
    wire         sda = ~(m_oe | d_oe);
    int          bad_count = 0, checks = 0, cyc = 0, nss = 0, nrs = 0, t0;

    bsr_ctrl_regs #(.STORE_CYC(24'h0002_bc), .RECALL_CYC(24'h0001_f4),
        .WCYCLE_CYC(24'h0001_c2)) bsr_ctrl_regs_inst (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(),
        .o_sda_oe(d_oe), .i_manual_backup_pin(hs), .i_cap_above_threshold(cap),
        .i_array_byte_written(awr), .i_array_addr(addr), .o_array_addr_protected(prot),
        .o_status(st), .o_busy(busy), .o_store_start(ss), .o_recall_start(rs));
    bsr_i2c_master bsr_i2c_master_inst (
        .i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

    always #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (ss === 1'b1) nss <= nss + 1;
        if (rs === 1'b1) nrs <= nrs + 1;
        if (cyc == 95000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    // ========================================
    // helpers
    function logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function logic pexp(input logic [2:0] c, input logic [8:0] a);
        return c == 3'h7 || (c != 3'h0 && {1'b0, a} >= 10'h200 - (10'h200 >> (3'h7 - c)));
    endfunction
    function logic [7:0] sexp(input logic m, input logic [7:0] w);
        return {m, 2'h0, w[4:0]};
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task pulse_wr;
        awr <= 1'b1;
        step(1);
        awr <= 1'b0;
        mod = 1'b1;
        step(4);
    endtask
    // busy may rise a few cycles late because the pins are synchronised
    task idle;
        step(12);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) step(1);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] dd);
        ak = 3'h0;
        bsr_i2c_master_inst.start;
        bsr_i2c_master_inst.send(8'h30, ak[2]);
        if (ak[2]) bsr_i2c_master_inst.send(a, ak[1]);
        if (ak[1]) bsr_i2c_master_inst.send(dd, ak[0]);
        bsr_i2c_master_inst.stop;
    endtask
    task rd(input logic [7:0] exp);
        bsr_i2c_master_inst.start;
        bsr_i2c_master_inst.send(8'h31, ak[2]);
        bsr_i2c_master_inst.recv(v);
        bsr_i2c_master_inst.stop;
        chk(v, exp);
    endtask
    task hs_pulse;
        hs <= 1'b1;
        step(40);
        hs <= 1'b0;
        idle;
        idle;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        step(16);
        i_rst <= 1'b0;
        chk(st, 8'h00);
        idle;
        rd(8'h00);
        $display("reset test done");
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            d = {rng[7:5], k[2:0], rng[1:0]};
            if (k == 4) pulse_wr;
            wr(8'h00, d);
            chk({5'h00, ak}, 8'h07);
            bsr_i2c_master_inst.start;
            bsr_i2c_master_inst.send(8'h30, ak[2]);
            bsr_i2c_master_inst.stop;
            chk({7'h00, ak[2]}, 8'h00);
            idle;
            rd(sexp(mod, d));
            pa = '{rng[16:8], 9'h1ff, 9'h000, 9'h1f7, 9'h1f8};
            for (int i = 0; i < 5; i++) begin
                addr <= pa[i];
                step(1);
                chk({7'h00, prot}, {7'h00, pexp(k[2:0], pa[i])});
            end
        end
        $display("status test done");
        for (int j = 0; j < 3; j++) begin
            if (j < 2) pulse_wr;
            t0 = nss + 2 * nrs;
            wr(8'h55, j == 1 ? 8'hdd : 8'h33);
            chk({5'h00, ak}, 8'h07);
            idle;
            chk(8'(nss + 2 * nrs - t0), j == 1 ? 8'h02 : 8'h01);
            mod = 1'b0;
            rd(sexp(1'b0, d));
        end
        t0 = nss + nrs;
        wr(8'h12, 8'h00);
        chk({5'h00, ak}, 8'h04);
        wr(8'h55, 8'h44);
        chk({5'h00, ak}, 8'h06);
        chk(8'(nss + nrs - t0), 8'h00);
        rd(sexp(1'b0, d));
        $display("command test done");
        for (int h = 0; h < 2; h++) begin
            wr(8'h00, 8'h00);
            idle;
            if (h == 1) pulse_wr;
            t0 = nss;
            hs_pulse;
            chk(8'(nss - t0), 8'(h));
            chk(st, 8'h01);
        end
        wr(8'h00, 8'h00);
        idle;
        pulse_wr;
        t0 = nss;
        cap <= 1'b0;
        step(20);
        hs_pulse;
        chk(8'(nss - t0), 8'h00);
        chk(st, 8'h80);
        cap <= 1'b1;
        idle;
        $display("pin test done");
        for (int e = 1; e >= 0; e--) begin
            pulse_wr;
            t0 = nss;
            wr(8'h00, {6'h00, e[0], 1'b0});
            step(20);
            cap <= 1'b0;
            idle;
            idle;
            chk(8'(nss - t0), 8'(e));
            cap <= 1'b1;
            idle;
        end
        $display("deferred store test done");
        tally_and_finish;
    end
endmodule // test_bsr_ctrl_regs
